/* File: design/aos_defs.svh */
// Constants for the analog output sequencer: register offsets, bit positions,
// reset values and timing counts.
// Assumes a 125 MHz system clock and 8-bit byte addresses on the register bus.
//
// Behaviour
// - Open buffer drops each sample once it has been sent to an output.
// - Writes to a full buffer are discarded; empty buffer leaves outputs idle.
// - Circular buffer recirculates its frame; host writes are refused while closed.
// - Entry bit 23 is the end-of-frame flag, marking the last value of a burst.
// - Outputs update on each selected clock while clocking is enabled, never otherwise.
// - Clock-accept flag is high whenever an output clock can be taken.
// - Outside-clock select high picks the clock pin, low picks divider A.
// - Soft clock bit gives exactly one clock event, then clears itself.
// - As clock initiator, pulse the shared clock pin with each internal clock.
// - As clock target with outside clock, falling edges on the pin are clocks.
// - Divider A uses a 24-bit divisor; both dividers idle until their run bits.
// - Divider rate equals master clock divided by divisor value.
// - With seven or fewer samples buffered, buffer reads slow to about 70 KSPS.
// - Each sample clock moves one whole channel group and updates it together.
// - Group-end on every value gives one channel per clock, in buffer order.
// - Continuous mode moves data while buffer is not empty and clocking enabled.
// - Burst trigger clocks values out until end-of-frame or empty, then waits.
// - Burst-accept flag is high when a trigger can be taken, low during bursts.
// - Trigger comes from the fire pin if outside-trigger set, else divider B.
// - Soft burst-fire bit raises one trigger and clears itself.
// - Trigger initiator pulses fire pin per burst not triggered from the fire pin; target detects falling edges.
// - Buffer operations register bits 0 to 8 hold the listed controls in order.
// - Host write to a closed buffer sets sticky data-loss bit 17 until written low.
`ifndef AOS_DEFS_SVH
`define AOS_DEFS_SVH

// ****************************************************************************
// Register offsets
// ****************************************************************************
`define AOS_OFF_BOARD_CTRL 8'h04
`define AOS_OFF_BUF_OPS    8'h0c
`define AOS_OFF_BUF_DATA   8'h18
`define AOS_OFF_BUF_SIZE   8'h1c
`define AOS_OFF_DIV_A      8'h24
`define AOS_OFF_DIV_B      8'h28

// ****************************************************************************
// Field positions
// ****************************************************************************
`define AOS_BO_EXT_CLK     0
`define AOS_BO_EXT_TRIG    1
`define AOS_BO_BURST_EN    2
`define AOS_BO_BURST_RDY   3
`define AOS_BO_SOFT_FIRE   4
`define AOS_BO_CLK_EN      5
`define AOS_BO_CLK_RDY     6
`define AOS_BO_SOFT_CLK    7
`define AOS_BO_CIRC        8
`define AOS_BO_CLEAR       11
`define AOS_BO_EMPTY       12
`define AOS_BO_FULL        15
`define AOS_BO_BUF_OVF     16
`define AOS_BO_FRAME_OVF   17
`define AOS_BC_CLK_INIT    0
`define AOS_BC_TRIG_INIT   1
`define AOS_BC_RUN_A       2
`define AOS_BC_RUN_B       3
`define AOS_ENT_EOF        23
`define AOS_ENT_GEND       22
`define AOS_ENT_CHAN_LO    16
`define AOS_HW_EOF         31
`define AOS_HW_GEND        30
`define AOS_HW_CHAN_LO     24

// ****************************************************************************
// Reset values and timing
// ****************************************************************************
`define AOS_DIV_A_RST      24'h0000c0
`define AOS_DIV_B_RST      24'h00c000
`define AOS_ALMOST_EMPTY   7
`define AOS_CLK_HZ         125000000
`define AOS_SLOW_RATE_SPS  70000
`define AOS_SLOW_READ_CYC  ((`AOS_CLK_HZ + `AOS_SLOW_RATE_SPS - 1) / `AOS_SLOW_RATE_SPS)

`endif

/* File: design/aos_pkg.sv */
// Types shared by the analog output sequencer modules.
// Assumes aos_defs.svh supplies the numeric constants.
package aos_pkg;
  typedef enum logic [0:0] {AOS_IDLE, AOS_MOVE} aos_state_t;
  typedef logic [23:0] aos_entry_t;
endpackage : aos_pkg

/* File: design/aos_rate_div.sv */
// Programmable rate divider producing a one-cycle tick.
// Assumes divisor is held steady by the register file on the same clock.
`timescale 1ns/1ps
module aos_rate_div import aos_pkg::*; #(
  parameter int W = 24
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         run,
  input  wire logic [W-1:0] divisor,
  output logic              tick
);
  logic [W-1:0] count;

  if (W < 2) begin : g_chk
    $error("aos_rate_div: W must be at least 2");
  end

  // ****************************************************************************
  // Divider
  // ****************************************************************************
  // Tick once every divisor cycles; divisors of 0 or 1 tick every cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count + W'(1) >= divisor) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + W'(1);
      tick  <= 1'b0;
    end
  end
endmodule : aos_rate_div

/* File: design/aos_pin_fall.sv */
// Two-flop synchroniser with falling-edge detection for a pin input.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/1ps
module aos_pin_fall import aos_pkg::*; (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      fall
);
  logic sync_a;
  logic sync_b;
  logic sync_c;

  // ****************************************************************************
  // Synchroniser
  // ****************************************************************************
  // Idle level of the shared pins is high, so the flops reset high.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sync_c <= 1'b1;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign fall = sync_c & ~sync_b;
endmodule : aos_pin_fall

/* File: design/aos_sequencer.sv */
// Analog output sequencer: sample buffer, clock and trigger selection,
// burst control and an AXI4-Lite register slave.
// Assumes one 125 MHz clock, synchronous active-low reset, and converter
// channels that latch chan_value on chan_write and update on chan_update.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "aos_defs.svh"
module aos_sequencer import aos_pkg::*; #(
  parameter int AW    = 18,
  parameter int DIV_W = 24
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        shared_clock_pin_in,
  output logic             shared_clock_pin_out,
  output logic             shared_clock_pin_oe,
  input  wire logic        shared_fire_pin_in,
  output logic             shared_fire_pin_out,
  output logic             shared_fire_pin_oe,
  output logic             chan_write,
  output logic [5:0]       chan_id,
  output logic [15:0]      chan_value,
  output logic             chan_update
);
  localparam logic [AW:0]  DEPTH  = (AW+1)'(1) << AW;
  localparam logic [AW:0]  ALMOST = (AW+1)'(`AOS_ALMOST_EMPTY);
  localparam logic [11:0]  SLOW   = 12'(`AOS_SLOW_READ_CYC - 1);

  if (AW < 4 || AW > 20 || DIV_W != 24) begin : g_chk
    $error("aos_sequencer: AW must be 4..20 and DIV_W must be 24");
  end

  // Register state.
  logic [3:0]       board_control_reg;
  logic             ext_clk, ext_trig, burst_en, soft_fire, clk_en, soft_clock_pulse, circ, clr;
  logic             buf_ovf, frame_ovf;
  logic [DIV_W-1:0] div_a, div_b;
  // Bus slave state.
  logic             aw_held, w_held;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             commit;
  // Buffer state.
  aos_entry_t       mem [1<<AW];
  logic [AW-1:0]    rd_ptr, wr_ptr, frame_start;
  logic [AW:0]      count;
  logic             circ_q;
  logic             buf_empty, buf_full, push, pop_open, host_push;
  aos_entry_t       rd_entry;
  // Engine state.
  aos_state_t       state;
  logic [11:0]      wait_cnt;
  logic             burst_active;
  logic             take_word, group_last, burst_stop, clock_ready, clk_evt, start_move, soft_clk_done;
  logic             tick_a, tick_b, clk_fall, fire_fall, trig_evt, trig_take;
  logic [31:0]      bo_word, rd_word;
  logic             rd_ok;

  // ****************************************************************************
  // Rate dividers and pin edge detectors
  // ****************************************************************************
  aos_rate_div #(.W(DIV_W)) u_div_a (
    .clock   (clock),
    .rst_n   (rst_n),
    .run     (board_control_reg[`AOS_BC_RUN_A]),
    .divisor (div_a),
    .tick    (tick_a)
  );
  aos_rate_div #(.W(DIV_W)) u_div_b (
    .clock   (clock),
    .rst_n   (rst_n),
    .run     (board_control_reg[`AOS_BC_RUN_B]),
    .divisor (div_b),
    .tick    (tick_b)
  );
  aos_pin_fall u_clk_pin (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (shared_clock_pin_in),
    .fall  (clk_fall)
  );
  aos_pin_fall u_fire_pin (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (shared_fire_pin_in),
    .fall  (fire_fall)
  );

  // ****************************************************************************
  // Byte-strobe merge
  // ****************************************************************************
  function automatic logic [31:0] aos_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : aos_merge

  // ****************************************************************************
  // AXI4-Lite slave
  // ****************************************************************************
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign commit        = aw_held && w_held && !s_axi_bvalid;

  // Address and data are latched independently, so either may arrive first.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (commit) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr inside {`AOS_OFF_BOARD_CTRL, `AOS_OFF_BUF_OPS, `AOS_OFF_BUF_DATA,
                         `AOS_OFF_BUF_SIZE, `AOS_OFF_DIV_A, `AOS_OFF_DIV_B}) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Buffer operations word as read back.
  always_comb begin
    bo_word = 32'h0000_0000;
    bo_word[`AOS_BO_EXT_CLK]   = ext_clk;
    bo_word[`AOS_BO_EXT_TRIG]  = ext_trig;
    bo_word[`AOS_BO_BURST_EN]  = burst_en;
    bo_word[`AOS_BO_BURST_RDY] = !burst_active;
    bo_word[`AOS_BO_SOFT_FIRE] = soft_fire;
    bo_word[`AOS_BO_CLK_EN]    = clk_en;
    bo_word[`AOS_BO_CLK_RDY]   = clock_ready;
    bo_word[`AOS_BO_SOFT_CLK]  = soft_clock_pulse;
    bo_word[`AOS_BO_CIRC]      = circ;
    bo_word[`AOS_BO_CLEAR]     = clr;
    bo_word[`AOS_BO_EMPTY]     = buf_empty;
    bo_word[`AOS_BO_FULL]      = buf_full;
    bo_word[`AOS_BO_BUF_OVF]   = buf_ovf;
    bo_word[`AOS_BO_FRAME_OVF] = frame_ovf;
  end

  // Read decode; the data port reads as zero because it is write-only.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      `AOS_OFF_BOARD_CTRL: rd_word = {28'h0000000, board_control_reg};
      `AOS_OFF_BUF_OPS:    rd_word = bo_word;
      `AOS_OFF_BUF_DATA:   rd_word = 32'h0000_0000;
      `AOS_OFF_BUF_SIZE:   rd_word = 32'(count);
      `AOS_OFF_DIV_A:      rd_word = {8'h00, div_a};
      `AOS_OFF_DIV_B:      rd_word = {8'h00, div_b};
      default:             rd_ok   = 1'b0;
    endcase
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************************
  // Control registers
  // ****************************************************************************
  // The soft clock bit drops on hardware completion, soft fire and clear after one
  // cycle; a bus write in the same cycle wins so a fresh request is never lost.
  always_ff @(posedge clock) begin
    logic [31:0] m;
    m = aos_merge(bo_word, w_data, w_strb);
    if (!rst_n) begin
      board_control_reg <= 4'h0;
      {ext_clk, ext_trig, burst_en, soft_fire, clk_en, soft_clock_pulse, circ, clr} <= 8'h00;
      div_a             <= `AOS_DIV_A_RST;
      div_b             <= `AOS_DIV_B_RST;
    end else begin
      if (soft_clk_done) begin
        soft_clock_pulse <= 1'b0;
      end
      soft_fire <= 1'b0;
      clr       <= 1'b0;
      if (commit) begin
        unique case (aw_addr)
          `AOS_OFF_BOARD_CTRL: board_control_reg <= 4'(aos_merge(32'(board_control_reg), w_data, w_strb));
          `AOS_OFF_BUF_OPS: begin
            ext_clk          <= m[`AOS_BO_EXT_CLK];
            ext_trig         <= m[`AOS_BO_EXT_TRIG];
            burst_en         <= m[`AOS_BO_BURST_EN];
            soft_fire        <= m[`AOS_BO_SOFT_FIRE];
            clk_en           <= m[`AOS_BO_CLK_EN];
            soft_clock_pulse <= m[`AOS_BO_SOFT_CLK];
            circ             <= m[`AOS_BO_CIRC];
            clr              <= m[`AOS_BO_CLEAR];
          end
          `AOS_OFF_DIV_A: div_a <= DIV_W'(aos_merge({8'h00, div_a}, w_data, w_strb));
          `AOS_OFF_DIV_B: div_b <= DIV_W'(aos_merge({8'h00, div_b}, w_data, w_strb));
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************************
  // Sticky data-loss flags
  // ****************************************************************************
  // A loss event in the cycle that software writes the flag low keeps it set.
  always_ff @(posedge clock) begin
    logic wr_bo;
    wr_bo = commit && aw_addr == `AOS_OFF_BUF_OPS && w_strb[2];
    if (!rst_n) begin
      buf_ovf   <= 1'b0;
      frame_ovf <= 1'b0;
    end else begin
      buf_ovf   <= (host_push && !circ && buf_full) ||
                   (buf_ovf && !(wr_bo && !w_data[`AOS_BO_BUF_OVF]));
      frame_ovf <= (host_push && circ) ||
                   (frame_ovf && !(wr_bo && !w_data[`AOS_BO_FRAME_OVF]));
    end
  end

  // ****************************************************************************
  // Sample buffer
  // ****************************************************************************
  assign buf_empty = count == '0;
  assign buf_full  = count == DEPTH;
  assign host_push = commit && aw_addr == `AOS_OFF_BUF_DATA && w_strb != 4'h0;
  assign push      = host_push && !circ && !buf_full;
  assign pop_open  = take_word && !circ;
  assign rd_entry  = mem[rd_ptr];

  // The storage has no reset so it can map onto block memory.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= {w_data[`AOS_HW_EOF], w_data[`AOS_HW_GEND],
                      w_data[`AOS_HW_CHAN_LO +: 6], w_data[15:0]};
    end
  end

  // Pointers; clearing the buffer overrides any push or pop in the same cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_ptr      <= '0;
      wr_ptr      <= '0;
      frame_start <= '0;
      count       <= '0;
      circ_q      <= 1'b0;
    end else begin
      circ_q <= circ;
      if (clr) begin
        rd_ptr      <= '0;
        wr_ptr      <= '0;
        frame_start <= '0;
        count       <= '0;
      end else begin
        if (circ && !circ_q) begin
          frame_start <= rd_ptr;
        end
        if (push) begin
          wr_ptr <= wr_ptr + AW'(1);
        end
        if (take_word) begin
          if (circ && (rd_entry[`AOS_ENT_EOF] || rd_ptr + AW'(1) == wr_ptr)) begin
            rd_ptr <= frame_start;
          end else begin
            rd_ptr <= rd_ptr + AW'(1);
          end
        end
        count <= count + (AW+1)'(push) - (AW+1)'(pop_open);
      end
    end
  end

  // ****************************************************************************
  // Clock and trigger selection
  // ****************************************************************************
  assign clock_ready   = state == AOS_IDLE && clk_en && !buf_empty && (!burst_en || burst_active);
  assign clk_evt       = clk_en && (soft_clock_pulse || (ext_clk ? clk_fall : tick_a));
  assign start_move    = clk_evt && clock_ready;
  assign soft_clk_done = soft_clock_pulse && clk_en && state == AOS_IDLE;
  assign trig_evt      = soft_fire || (ext_trig ? fire_fall : tick_b);
  assign trig_take     = trig_evt && burst_en && !burst_active;

  // Initiator pins drive a one-cycle low pulse; targets leave the pin released.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shared_clock_pin_out <= 1'b1;
      shared_clock_pin_oe  <= 1'b0;
      shared_fire_pin_out  <= 1'b1;
      shared_fire_pin_oe   <= 1'b0;
    end else begin
      shared_clock_pin_oe  <= board_control_reg[`AOS_BC_CLK_INIT];
      shared_clock_pin_out <= !(board_control_reg[`AOS_BC_CLK_INIT] && !ext_clk &&
                                ((clk_en && tick_a) || soft_clk_done));
      shared_fire_pin_oe   <= board_control_reg[`AOS_BC_TRIG_INIT];
      shared_fire_pin_out  <= !(board_control_reg[`AOS_BC_TRIG_INIT] && trig_take &&
                                !(ext_trig && !soft_fire));
    end
  end

  // ****************************************************************************
  // Burst control
  // ****************************************************************************
  assign burst_stop = burst_active && ((take_word && rd_entry[`AOS_ENT_EOF]) || buf_empty);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      burst_active <= 1'b0;
    end else if (trig_take) begin
      burst_active <= 1'b1;
    end else if (burst_stop || !burst_en) begin
      burst_active <= 1'b0;
    end
  end

  // ****************************************************************************
  // Transfer engine
  // ****************************************************************************
  assign take_word  = state == AOS_MOVE && wait_cnt == 12'h000 && !buf_empty;
  assign group_last = rd_entry[`AOS_ENT_GEND] || rd_entry[`AOS_ENT_EOF];

  // Each clock moves one channel group, one entry per step; reads are spaced
  // out when the buffer is almost empty, which caps the reachable rate.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state       <= AOS_IDLE;
      wait_cnt    <= 12'h000;
      chan_write  <= 1'b0;
      chan_update <= 1'b0;
      chan_id     <= 6'h00;
      chan_value  <= 16'h0000;
    end else begin
      chan_write  <= 1'b0;
      chan_update <= 1'b0;
      unique case (state)
        AOS_IDLE: begin
          if (start_move) begin
            state    <= AOS_MOVE;
            wait_cnt <= (count <= ALMOST) ? SLOW : 12'h000;
          end
        end
        AOS_MOVE: begin
          if (wait_cnt != 12'h000) begin
            wait_cnt <= wait_cnt - 12'h001;
          end else if (buf_empty) begin
            chan_update <= 1'b1;
            state       <= AOS_IDLE;
          end else begin
            chan_write <= 1'b1;
            chan_id    <= rd_entry[`AOS_ENT_CHAN_LO +: 6];
            chan_value <= rd_entry[15:0];
            if (group_last) begin
              chan_update <= 1'b1;
              state       <= AOS_IDLE;
            end else begin
              wait_cnt <= (count <= ALMOST + (AW+1)'(1)) ? SLOW : 12'h000;
            end
          end
        end
      endcase
    end
  end
endmodule : aos_sequencer

/* File: verif/aos_seq_assertions.sv */
// Port checks for the analog output sequencer.
// Assumes one clock domain; bound onto aos_sequencer.
`timescale 1ns/1ps
module aos_seq_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic chan_write,
  input wire logic chan_update,
  input wire logic shared_clock_pin_out,
  input wire logic shared_clock_pin_oe,
  input wire logic shared_fire_pin_out,
  input wire logic shared_fire_pin_oe
);
  // ****************************************************************
  // Relations between outputs
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rblk: assert property (p_rblk) else $error("read address taken while data held.");
  property p_rlat; $rose(s_axi_rvalid) |-> $past(s_axi_arready); endproperty
  a_rlat: assert property (p_rlat) else $error("read data without an address.");
  property p_upd; chan_update |-> chan_write; endproperty
  a_upd: assert property (p_upd) else $error("update without a last write.");
  property p_upd1; chan_update |=> !chan_update; endproperty
  a_upd1: assert property (p_upd1) else $error("two updates in a row.");
  property p_cpul; !shared_clock_pin_out |=> shared_clock_pin_out; endproperty
  a_cpul: assert property (p_cpul) else $error("clock pin pulse too long.");
  property p_coe; !shared_clock_pin_oe |-> shared_clock_pin_out; endproperty
  a_coe: assert property (p_coe) else $error("clock pulse while target.");
  property p_fpul; !shared_fire_pin_out |=> shared_fire_pin_out; endproperty
  a_fpul: assert property (p_fpul) else $error("fire pin pulse too long.");
  property p_foe; !shared_fire_pin_oe |-> shared_fire_pin_out; endproperty
  a_foe: assert property (p_foe) else $error("fire pulse while target.");
endmodule : aos_seq_assertions
bind aos_sequencer aos_seq_assertions u_chk (.clock(clock), .rst_n(rst_n), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .chan_write(chan_write), .chan_update(chan_update),
  .shared_clock_pin_out(shared_clock_pin_out), .shared_clock_pin_oe(shared_clock_pin_oe),
  .shared_fire_pin_out(shared_fire_pin_out), .shared_fire_pin_oe(shared_fire_pin_oe));

/* File: verif/aos_pin_partner.sv */
// Another board on the shared clock pin; the line has a pull-up.
// Assumes the bench raises req once to ask for one falling edge.
`timescale 1ns/1ps
module aos_pin_partner (
  input  wire logic req,
  input  wire logic oe,
  input  wire logic out,
  output logic      level
);
  logic drv = 1'b1;
  // A low pulse of five master clocks, so the falling edge survives the synchroniser.
  always @(posedge req) begin
    drv = 1'b0;
    #40 drv = 1'b1;
  end
  assign level = oe ? out : drv;
endmodule : aos_pin_partner

/* File: verif/aos_sequencer_tb.sv */
// Bench: registers, draining, overflow, circular refusal, pin clock.
// Assumes the handed-over bus timing; buffer depth cut to 64.
`timescale 1ns/1ps
module aos_sequencer_tb;
  logic clock = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, req = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] chan_value, v, exp_q[$], got_q[$];
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, chan_write, chan_update;
  logic shared_clock_pin_out, shared_clock_pin_oe, lvl;
  int fails = 0, n_compared = 0, cyc = 0, seed = 72351;
  aos_sequencer #(.AW(6)) uut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1), .shared_clock_pin_in(lvl), .shared_clock_pin_out, .shared_clock_pin_oe,
    .shared_fire_pin_in(1'b1), .shared_fire_pin_out(), .shared_fire_pin_oe(), .chan_write, .chan_id(),
    .chan_value, .chan_update);
  aos_pin_partner peer (.req(req), .oe(shared_clock_pin_oe), .out(shared_clock_pin_out), .level(lvl));
  initial forever #4 clock = ~clock;
  // Slow reads near empty cost 1786 cycles each, so the ceiling is generous.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      report_and_stop();
    end
  end
  always @(posedge clock) if (chan_write) got_q.push_back(chan_value);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, 2'h0);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, (a == 8'h30) ? 2'h2 : 2'h0);
  endtask : rd
  // Random values; the last entry closes both group and frame.
  task load(input int n);
    for (int i = 0; i < n; i++) begin
      v = $random(seed);
      exp_q.push_back(v);
      wr(8'h18, {i == n - 1, i == n - 1, i[5:0], 8'h00, v});
    end
  endtask : load
  task drain();
    wait (got_q.size() == exp_q.size());
    while (exp_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front());
  endtask : drain
  task report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    rd(8'h0c, 32'h1008);
    rd(8'h24, 32'hc0);
    rd(8'h28, 32'hc000);
    rd(8'h30, 32'h0);
    wr(8'h24, 32'hfa);
    rd(8'h24, 32'hfa);
    $display("reset test done");
    wr(8'h04, 32'h1);
    load(2);
    wr(8'h0c, 32'ha0);
    drain();
    rd(8'h1c, 32'h0);
    rd(8'h0c, 32'h1028);
    $display("soft clock test done");
    wr(8'h0c, 32'h0);
    wr(8'h04, 32'h0);
    for (int i = 0; i < 65; i++) wr(8'h18, $random(seed));
    rd(8'h1c, 32'd64);
    rd(8'h0c, 32'h18008);
    wr(8'h0c, 32'h800);
    wr(8'h0c, 32'h100);
    wr(8'h18, 32'h0);
    rd(8'h0c, 32'h21108);
    rd(8'h1c, 32'h0);
    $display("overflow test done");
    wr(8'h0c, 32'h0);
    wr(8'h04, 32'h4);
    load(2);
    wr(8'h0c, 32'h34);
    drain();
    rd(8'h0c, 32'h102c);
    $display("burst test done");
    load(1);
    wr(8'h0c, 32'h21);
    req <= 1;
    drain();
    $display("pin clock test done");
    report_and_stop();
  end
endmodule : aos_sequencer_tb
